// ---- design/file_reg_bank.sv ----
// file register space with one write port and two asynchronous read ports
`timescale 1ns/1ns
`include "exec_slice_map.svh"
module file_reg_bank #(
  parameter int ADDR_W = 7,
  parameter int DATA_W = 8
) (
  input  wire logic              clk_in,
  input  wire logic              rst_n_in,
  input  wire logic              wr_en_in,
  input  wire logic [ADDR_W-1:0] wr_addr_in,
  input  wire logic [DATA_W-1:0] wr_data_in,
  input  wire logic [ADDR_W-1:0] rd_addr_in,
  output logic      [DATA_W-1:0] rd_data_out,
  input  wire logic [ADDR_W-1:0] peek_addr_in,
  output logic      [DATA_W-1:0] peek_data_out
);
  localparam int DEPTH = 1 << ADDR_W;
  logic [DATA_W-1:0] mem_r [DEPTH];

  // every location clears on reset so reads are defined
  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
        mem_r[i] <= DATA_W'(`DATA_RESET_VAL);
      end else if (wr_en_in && wr_addr_in == ADDR_W'(i)) begin
        mem_r[i] <= wr_data_in;
      end
    end
  end

  assign rd_data_out   = mem_r[rd_addr_in];
  assign peek_data_out = mem_r[peek_addr_in];
endmodule

// ---- design/inc_dec_or_move_exec_slice.sv ----
// execution slice for increment, skip, OR and move instructions
// How it works
// - register operands use a 7-bit address; target 0 is acc, 1 is file
// - increment adds one to the file value, writes target, updates zero
// - decrement-skip subtracts one, writes target, leaves flags alone
// - decrement-skip with zero result discards next instruction as a nop
// - increment-skip adds one, leaves flags, skips next on zero result
// - or-literal ORs the literal into acc and updates zero
// - load-literal copies the literal to acc, flags unchanged
// - or-register ORs acc with file, writes target, updates zero
// - store copies acc into the file register, flags unchanged
`timescale 1ns/1ns
`include "exec_slice_map.svh"
module inc_dec_or_move_exec_slice #(
  parameter int ADDR_W = 7,
  parameter int DATA_W = 8
) (
  input  wire logic              SYS_CLK_IN,
  input  wire logic              RST_N_IN,
  input  wire logic              INSTR_VALID_IN,
  input  wire logic [2:0]        OPCODE_IN,
  input  wire logic [ADDR_W-1:0] FILE_ADDR_IN,
  input  wire logic              TARGET_SEL_IN,
  input  wire logic [DATA_W-1:0] LITERAL_IN,
  input  wire logic [ADDR_W-1:0] PEEK_ADDR_IN,
  output logic      [DATA_W-1:0] ACC_OUT,
  output logic                   ZERO_OUT,
  output logic      [DATA_W-1:0] RESULT_OUT,
  output logic                   DONE_OUT,
  output logic                   FILE_WR_OUT,
  output logic                   SKIP_NEXT_OUT,
  output logic      [DATA_W-1:0] PEEK_DATA_OUT
);
  exec_slice_pkg::slice_state_t state_r;
  exec_slice_pkg::slice_state_t state_nxt;
  exec_slice_pkg::opcode_t      op;
  logic [DATA_W-1:0] acc_r;
  logic [DATA_W-1:0] acc_nxt;
  logic              zero_r;
  logic              zero_nxt;
  logic [DATA_W-1:0] result_r;
  logic              done_r;
  logic              file_wr_r;
  logic              skip_r;
  logic [DATA_W-1:0] peek_r;
  logic [DATA_W-1:0] file_rd;
  logic [DATA_W-1:0] peek_rd;
  logic [DATA_W-1:0] result;
  logic              take;
  logic              is_inc;
  logic              is_dec_sz;
  logic              is_inc_sz;
  logic              is_orl;
  logic              is_movl;
  logic              is_orr;
  logic              is_store;
  logic              reg_form;
  logic              wr_file;
  logic              wr_acc;
  logic              upd_zero;
  logic              res_zero;
  logic              skip_hit;

  assign op        = exec_slice_pkg::opcode_t'(OPCODE_IN);
  // an instruction is taken only in the execute state; the one after a
  // taken skip falls into the nop cycle and is dropped
  assign take      = INSTR_VALID_IN
                     && state_r == exec_slice_pkg::EXECUTE;
  assign is_inc    = take && op == exec_slice_pkg::INCREMENT_REG;
  assign is_dec_sz = take && op == exec_slice_pkg::DECREMENT_SKIP_ZERO;
  assign is_inc_sz = take && op == exec_slice_pkg::INCREMENT_SKIP_ZERO;
  assign is_orl    = take && op == exec_slice_pkg::OR_LITERAL_ACC;
  assign is_movl   = take && op == exec_slice_pkg::LOAD_LITERAL_ACC;
  assign is_orr    = take && op == exec_slice_pkg::OR_ACC_REG;
  assign is_store  = take && op == exec_slice_pkg::STORE_ACC_REG;
  assign reg_form  = is_inc || is_dec_sz || is_inc_sz || is_orr;

  // result selection; the reserved code yields the accumulator untouched
  assign result =
      (is_inc || is_inc_sz) ? DATA_W'(file_rd + `STEP_ONE) :
      is_dec_sz             ? DATA_W'(file_rd - `STEP_ONE) :
      is_orl                ? (acc_r | LITERAL_IN)         :
      is_movl               ? LITERAL_IN                   :
      is_orr                ? (acc_r | file_rd)            :
      acc_r;

  assign wr_file  = (reg_form && TARGET_SEL_IN == `TARGET_FILE)
                    || is_store;
  assign wr_acc   = (reg_form && TARGET_SEL_IN == `TARGET_ACC)
                    || is_orl || is_movl;
  assign upd_zero = is_inc || is_orl || is_orr;
  assign res_zero = result == DATA_W'(`ZERO_BYTE);
  assign skip_hit = (is_dec_sz || is_inc_sz) && res_zero;
  assign acc_nxt  = wr_acc ? result : acc_r;
  assign zero_nxt = upd_zero ? res_zero : zero_r;
  assign state_nxt = skip_hit ? exec_slice_pkg::SKIP_NOP
                              : exec_slice_pkg::EXECUTE;

  file_reg_bank #(
    .ADDR_W (ADDR_W),
    .DATA_W (DATA_W)
  ) u_bank (
    .clk_in        (SYS_CLK_IN),
    .rst_n_in      (RST_N_IN),
    .wr_en_in      (wr_file),
    .wr_addr_in    (FILE_ADDR_IN),
    .wr_data_in    (result),
    .rd_addr_in    (FILE_ADDR_IN),
    .rd_data_out   (file_rd),
    .peek_addr_in  (PEEK_ADDR_IN),
    .peek_data_out (peek_rd)
  );

  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      state_r <= exec_slice_pkg::EXECUTE;
      acc_r   <= DATA_W'(`ACC_RESET_VAL);
      zero_r  <= `ZERO_RESET_VAL;
    end else begin
      state_r <= state_nxt;
      acc_r   <= acc_nxt;
      zero_r  <= zero_nxt;
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      result_r  <= DATA_W'(`DATA_RESET_VAL);
      done_r    <= 1'b0;
      file_wr_r <= 1'b0;
      skip_r    <= 1'b0;
      peek_r    <= DATA_W'(`DATA_RESET_VAL);
    end else begin
      result_r  <= take ? result : result_r;
      done_r    <= take;
      file_wr_r <= wr_file;
      skip_r    <= skip_hit;
      peek_r    <= peek_rd;
    end
  end

  // the state register is two-valued, so the nop cycle is a plain case
  logic in_nop;
  always_comb begin
    case (state_r)
      exec_slice_pkg::SKIP_NOP: in_nop = 1'b1;
      exec_slice_pkg::EXECUTE:  in_nop = 1'b0;
      default:                  in_nop = 1'b0;
    endcase
  end

  assign ACC_OUT       = acc_r;
  assign ZERO_OUT      = zero_r;
  assign RESULT_OUT    = result_r;
  assign DONE_OUT      = done_r;
  assign FILE_WR_OUT   = file_wr_r;
  assign SKIP_NEXT_OUT = skip_r;
  assign PEEK_DATA_OUT = peek_r;

  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RST_N_IN);

  sequence s_skip_taken;
    (is_dec_sz || is_inc_sz) && res_zero;
  endsequence
  sequence s_nop_then_back;
    in_nop && SKIP_NEXT_OUT && !take ##1 !in_nop;
  endsequence

  a_inc_acc_value: assert property (
    is_inc && !TARGET_SEL_IN |=>
      ACC_OUT == DATA_W'($past(file_rd) + `STEP_ONE)
      && ZERO_OUT == (ACC_OUT == DATA_W'(`ZERO_BYTE)))
    else $error("increment to acc gave a wrong value or zero flag");

  a_dec_flag_hold: assert property (
    is_dec_sz |=> $stable(ZERO_OUT)
      && RESULT_OUT == DATA_W'($past(file_rd) - `STEP_ONE))
    else $error("decrement-skip changed zero or computed wrongly");

  a_skip_nop_cycle: assert property (
    s_skip_taken |=> s_nop_then_back)
    else $error("taken skip did not insert exactly one nop cycle");

  a_no_skip_go: assert property (
    (is_dec_sz || is_inc_sz) && !res_zero |=> !in_nop && !SKIP_NEXT_OUT)
    else $error("skip inserted although result was nonzero");

  a_incsz_flag_hold: assert property (
    is_inc_sz |=> $stable(ZERO_OUT)
      && RESULT_OUT == DATA_W'($past(file_rd) + `STEP_ONE))
    else $error("increment-skip changed zero or computed wrongly");

  a_orl_acc_zero: assert property (
    is_orl |=> ACC_OUT == ($past(acc_r) | $past(LITERAL_IN))
      && ZERO_OUT == (ACC_OUT == DATA_W'(`ZERO_BYTE)))
    else $error("or-literal wrong value or zero flag");

  a_movl_no_flag: assert property (
    is_movl |=> ACC_OUT == $past(LITERAL_IN) && $stable(ZERO_OUT))
    else $error("load-literal wrong value or touched zero flag");

  a_orr_file_wr: assert property (
    is_orr && TARGET_SEL_IN |=> FILE_WR_OUT && $stable(ACC_OUT)
      && RESULT_OUT == ($past(acc_r) | $past(file_rd)))
    else $error("or-register to file went astray");

  a_store_keeps: assert property (
    is_store |=> FILE_WR_OUT && RESULT_OUT == $past(acc_r)
      && $stable(ACC_OUT) && $stable(ZERO_OUT))
    else $error("store did not write the accumulator to the file");

  a_zero_tracks: assert property (
    upd_zero |=> ZERO_OUT == (RESULT_OUT == DATA_W'(`ZERO_BYTE)))
    else $error("zero flag disagrees with result");

  a_single_cycle: assert property (
    take && !skip_hit |=> DONE_OUT && !in_nop)
    else $error("instruction did not finish in one cycle");

  a_target_acc: assert property (
    reg_form && !TARGET_SEL_IN |=> !FILE_WR_OUT)
    else $error("target select 0 still wrote the file register");
endmodule

// ---- pkg/exec_slice_map.svh ----
// constant map of the increment, decrement, OR and move execution slice
`ifndef EXEC_SLICE_MAP_SVH
`define EXEC_SLICE_MAP_SVH
`define OPC_INCREMENT_REG        3'h0
`define OPC_DECREMENT_SKIP_ZERO  3'h1
`define OPC_INCREMENT_SKIP_ZERO  3'h2
`define OPC_OR_LITERAL_ACC       3'h3
`define OPC_LOAD_LITERAL_ACC     3'h4
`define OPC_OR_ACC_REG           3'h5
`define OPC_STORE_ACC_REG        3'h6
`define OPC_RESERVED             3'h7
`define ST_EXECUTE               1'b0
`define ST_SKIP_NOP              1'b1
`define TARGET_ACC               1'b0
`define TARGET_FILE              1'b1
`define ACC_RESET_VAL            8'h00
`define ZERO_RESET_VAL           1'b0
`define DATA_RESET_VAL           8'h00
`define STEP_ONE                 8'h01
`define ZERO_BYTE                8'h00
`define FILE_ADDR_MAX            7'h7f
`endif

// ---- pkg/exec_slice_pkg.sv ----
// types shared by the execution slice
`include "exec_slice_map.svh"
package exec_slice_pkg;
  typedef enum logic [2:0] {
    INCREMENT_REG       = `OPC_INCREMENT_REG,
    DECREMENT_SKIP_ZERO = `OPC_DECREMENT_SKIP_ZERO,
    INCREMENT_SKIP_ZERO = `OPC_INCREMENT_SKIP_ZERO,
    OR_LITERAL_ACC      = `OPC_OR_LITERAL_ACC,
    LOAD_LITERAL_ACC    = `OPC_LOAD_LITERAL_ACC,
    OR_ACC_REG          = `OPC_OR_ACC_REG,
    STORE_ACC_REG       = `OPC_STORE_ACC_REG,
    OP_RESERVED         = `OPC_RESERVED
  } opcode_t;
  typedef enum logic {
    EXECUTE  = `ST_EXECUTE,
    SKIP_NOP = `ST_SKIP_NOP
  } slice_state_t;
endpackage

// ---- testbench/inc_dec_or_move_exec_slice_test.sv ----
// self-checking bench for the increment, skip, OR and move slice
`timescale 1ns/1ns
module inc_dec_or_move_exec_slice_test;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic [6:0] peek_addr = 7'h00;
  logic       valid, sel, zero, done, file_wr, skip;
  logic [2:0] opcode;
  logic [6:0] addr;
  logic [7:0] lit, acc, result, peek_data;
  int         failures = 0;
  int         n_checks = 0;
  int         cycles = 0;
  always #25 clk = ~clk;
  instr_sequencer i_seq (.clk_in(clk), .skip_in(skip), .valid_out(valid),
    .opcode_out(opcode), .addr_out(addr), .sel_out(sel), .lit_out(lit));
  inc_dec_or_move_exec_slice i_dut (.SYS_CLK_IN(clk), .RST_N_IN(rst_n),
    .INSTR_VALID_IN(valid), .OPCODE_IN(opcode), .FILE_ADDR_IN(addr),
    .TARGET_SEL_IN(sel), .LITERAL_IN(lit), .PEEK_ADDR_IN(peek_addr),
    .ACC_OUT(acc), .ZERO_OUT(zero), .RESULT_OUT(result), .DONE_OUT(done),
    .FILE_WR_OUT(file_wr), .SKIP_NEXT_OUT(skip),
    .PEEK_DATA_OUT(peek_data));
  task automatic chk(input string what, input logic [7:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic az(input logic [7:0] a, input logic z);
    chk("acc", acc, a);
    chk("zero", {7'h00, zero}, {7'h00, z});
  endtask
  task automatic run(input exec_slice_pkg::opcode_t op,
                     input logic [6:0] a, input logic s,
                     input logic [7:0] k);
    i_seq.issue(op, a, s, k);
    i_seq.idle();
    chk("done", {7'h00, done}, 8'h01);
  endtask
  task automatic peek(input logic [6:0] a, input logic [7:0] exp);
    @(posedge clk);
    peek_addr <= a;
    @(posedge clk);
    @(negedge clk);
    chk("file", peek_data, exp);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      failures++;
      end_sim();
    end
  end
  task automatic t_literal();
    run(exec_slice_pkg::LOAD_LITERAL_ACC, 7'h00, 1'b0, 8'h00);
    az(8'h00, 1'b0);
    run(exec_slice_pkg::OR_LITERAL_ACC, 7'h00, 1'b0, 8'h00);
    az(8'h00, 1'b1);
    run(exec_slice_pkg::LOAD_LITERAL_ACC, 7'h00, 1'b0, 8'ha5);
    az(8'ha5, 1'b1);
    run(exec_slice_pkg::OR_LITERAL_ACC, 7'h00, 1'b0, 8'h5a);
    az(8'hff, 1'b0);
    $display("test literal done");
  endtask
  task automatic t_store_inc();
    run(exec_slice_pkg::STORE_ACC_REG, 7'h7f, 1'b0, 8'h00);
    chk("file_wr", {7'h00, file_wr}, 8'h01);
    peek(7'h7f, 8'hff);
    run(exec_slice_pkg::INCREMENT_REG, 7'h7f, 1'b0, 8'h00);
    az(8'h00, 1'b1);
    peek(7'h7f, 8'hff);
    run(exec_slice_pkg::INCREMENT_REG, 7'h7f, 1'b1, 8'h00);
    run(exec_slice_pkg::INCREMENT_REG, 7'h7f, 1'b1, 8'h00);
    az(8'h00, 1'b0);
    peek(7'h7f, 8'h01);
    $display("test store and increment done");
  endtask
  task automatic t_dec_skip();
    run(exec_slice_pkg::LOAD_LITERAL_ACC, 7'h00, 1'b0, 8'h33);
    i_seq.issue(exec_slice_pkg::DECREMENT_SKIP_ZERO, 7'h7f, 1'b1, 8'h00);
    i_seq.issue(exec_slice_pkg::LOAD_LITERAL_ACC, 7'h00, 1'b0, 8'h77);
    chk("taken", {7'h00, i_seq.taken}, 8'h00);
    i_seq.idle();
    az(8'h33, 1'b0);
    chk("skip", {7'h00, skip}, 8'h00);
    chk("done", {7'h00, done}, 8'h00);
    peek(7'h7f, 8'h00);
    i_seq.issue(exec_slice_pkg::DECREMENT_SKIP_ZERO, 7'h7f, 1'b0, 8'h00);
    i_seq.issue(exec_slice_pkg::LOAD_LITERAL_ACC, 7'h00, 1'b0, 8'h11);
    chk("taken", {7'h00, i_seq.taken}, 8'h01);
    az(8'hff, 1'b0);
    i_seq.idle();
    az(8'h11, 1'b0);
    $display("test decrement skip done");
  endtask
  task automatic t_inc_skip();
    run(exec_slice_pkg::LOAD_LITERAL_ACC, 7'h00, 1'b0, 8'hff);
    run(exec_slice_pkg::STORE_ACC_REG, 7'h10, 1'b1, 8'h00);
    i_seq.issue(exec_slice_pkg::INCREMENT_SKIP_ZERO, 7'h10, 1'b1, 8'h00);
    i_seq.issue(exec_slice_pkg::LOAD_LITERAL_ACC, 7'h00, 1'b0, 8'h44);
    chk("taken", {7'h00, i_seq.taken}, 8'h00);
    i_seq.idle();
    az(8'hff, 1'b0);
    peek(7'h10, 8'h00);
    i_seq.issue(exec_slice_pkg::INCREMENT_SKIP_ZERO, 7'h10, 1'b0, 8'h00);
    i_seq.issue(exec_slice_pkg::LOAD_LITERAL_ACC, 7'h00, 1'b0, 8'h22);
    chk("taken", {7'h00, i_seq.taken}, 8'h01);
    az(8'h01, 1'b0);
    i_seq.idle();
    az(8'h22, 1'b0);
    $display("test increment skip done");
  endtask
  task automatic t_or_reg();
    run(exec_slice_pkg::LOAD_LITERAL_ACC, 7'h00, 1'b0, 8'h0f);
    run(exec_slice_pkg::STORE_ACC_REG, 7'h20, 1'b0, 8'h00);
    run(exec_slice_pkg::LOAD_LITERAL_ACC, 7'h00, 1'b0, 8'hf0);
    run(exec_slice_pkg::OR_ACC_REG, 7'h20, 1'b1, 8'h00);
    az(8'hf0, 1'b0);
    chk("result", result, 8'hff);
    peek(7'h20, 8'hff);
    run(exec_slice_pkg::LOAD_LITERAL_ACC, 7'h00, 1'b0, 8'h00);
    run(exec_slice_pkg::OR_ACC_REG, 7'h30, 1'b0, 8'h00);
    az(8'h00, 1'b1);
    chk("file_wr", {7'h00, file_wr}, 8'h00);
    run(exec_slice_pkg::OP_RESERVED, 7'h30, 1'b1, 8'h5a);
    az(8'h00, 1'b1);
    chk("file_wr", {7'h00, file_wr}, 8'h00);
    $display("test or register done");
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    az(8'h00, 1'b0);
    peek(7'h7f, 8'h00);
    t_literal();
    t_store_inc();
    t_dec_skip();
    t_inc_skip();
    t_or_reg();
    end_sim();
  end
endmodule

// ---- testbench/instr_sequencer.sv ----
// sequencer model that presents instructions to the execution slice
`timescale 1ns/1ns
module instr_sequencer (
  input  wire logic       clk_in,
  input  wire logic       skip_in,
  output logic            valid_out,
  output logic      [2:0] opcode_out,
  output logic      [6:0] addr_out,
  output logic            sel_out,
  output logic      [7:0] lit_out
);
  logic taken;
  initial begin
    valid_out  = 1'b0;
    opcode_out = 3'h0;
    addr_out   = 7'h00;
    sel_out    = 1'b0;
    lit_out    = 8'h00;
    taken      = 1'b0;
  end
  // taken goes low when the instruction sits in the nop cycle
  task automatic issue(input exec_slice_pkg::opcode_t op,
                       input logic [6:0] a, input logic s,
                       input logic [7:0] k);
    @(posedge clk_in);
    valid_out  <= 1'b1;
    opcode_out <= op;
    addr_out   <= a;
    sel_out    <= s;
    lit_out    <= k;
    @(negedge clk_in);
    taken = !skip_in;
  endtask
  // released address and literal fields flip so stale values are never mistaken for data
  task automatic idle();
    @(posedge clk_in);
    valid_out <= 1'b0;
    addr_out  <= ~addr_out;
    lit_out   <= ~lit_out;
    @(negedge clk_in);
  endtask
endmodule
